//--- design/lfs_ch_if.sv
`timescale 1ns/1ps
interface lfs_ch_if;
	logic clear;
	logic run;
	logic force_open;
	logic fast;
	logic pwm_tick;
	logic fast_tick;
	logic cur_ok;
	logic over_short;
	logic disabled;
	modport top (output clear, run, force_open, fast, pwm_tick, fast_tick, output cur_ok, over_short, input disabled);
	modport ch (input clear, run, force_open, fast, pwm_tick, fast_tick, cur_ok, over_short, output disabled);
endinterface

//--- design/lfs_channel.sv
`timescale 1ns/1ps
`include "lfs_map.svh"
module lfs_channel (
	input wire logic core_clk, // clock
	input wire logic resetn, // async reset, active low
	lfs_ch_if.ch cif // channel controls and status
);
	logic good_reg;
	logic open_reg;
	logic dis_reg;
	logic [2:0] cnt_reg;
	logic fast_seen_reg;

	assign cif.disabled = dis_reg;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			good_reg <= 1'b0;
		end else if (cif.clear) begin
			good_reg <= 1'b0;
		end else if (cif.run && cif.cur_ok) begin
			good_reg <= 1'b1;
		end else if (cif.run && good_reg && !cif.cur_ok) begin
			good_reg <= 1'b0;
		end
	end

	// open marking: current drop after good, or forced while not good
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			open_reg <= 1'b0;
		end else if (cif.clear || !cif.run || cif.cur_ok) begin
			open_reg <= 1'b0;
		end else if (good_reg || cif.force_open) begin
			open_reg <= 1'b1;
		end
	end

	// time-out count: six pwm periods, or one fast period when hot
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 3'h0;
			fast_seen_reg <= 1'b0;
		end else if (!open_reg && !cif.over_short) begin
			cnt_reg <= 3'h0;
			fast_seen_reg <= 1'b0;
		end else begin
			if (cif.pwm_tick && cnt_reg != `LFS_PWM_TIMEOUT)
				cnt_reg <= cnt_reg + 3'h1;
			if (cif.fast && cif.fast_tick)
				fast_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dis_reg <= 1'b0;
		end else if (cif.clear) begin
			dis_reg <= 1'b0;
		end else if (cnt_reg == `LFS_PWM_TIMEOUT || fast_seen_reg) begin
			dis_reg <= 1'b1;
		end
	end
endmodule

//--- design/lfs_map.svh
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH
`define LFS_NUM_CH 6
`define LFS_CLK_MHZ 50
`define LFS_OPEN_FAST_US 800
`define LFS_OPEN_FAST_CYC (`LFS_OPEN_FAST_US * `LFS_CLK_MHZ)
`define LFS_PWM_TIMEOUT 3'h6
`define LFS_PWR_SHORT_MS 31
`define LFS_PWR_SHORT_CYC (`LFS_PWR_SHORT_MS * 1000 * `LFS_CLK_MHZ)
`define LFS_SCALE_FULL 2'h0
`define LFS_SCALE_75 2'h1
`define LFS_SCALE_50 2'h2
`define LFS_SCALE_25 2'h3
`endif

//--- design/lfs_pkg.sv
package lfs_pkg;
	typedef enum logic [1:0] {LFS_OFF, LFS_RUN, LFS_THERMAL, LFS_DEAD} lfs_state_e;
	typedef logic [1:0] lfs_scale_t;
endpackage

//--- design/lfs_supervisor.sv
`timescale 1ns/1ps
`include "lfs_map.svh"
// Notes on behaviour
// - when lower temperature flag is set, channels well below target count as open.
// - above lower temperature, open-channel time-out is a fixed 800 us.
// - each upper temperature trip stops boost and all current sinks.
// - after trip, restart on cool-down flag with current scaled to 75 percent.
// - further trips step the scale to 50 then 25 percent, which stays.
// - thermal cycles return to the active state; only enable low or an output short leaves the cycle.
// - thermal shutdown turns off good and faulty channels alike; 75 percent used.
// - channel below the short threshold stays enabled, others run normally.
// - channel above short threshold disabled after six PWM periods.
// - open channel raising output to over-voltage times out after six PWM periods.
// - zener-bypassed open channel below over-voltage stays on.
// - over-voltage makes every channel below target time out after six periods.
// - output or switch node short to ground shuts down permanently 31 ms after power-up.
// - switch node checks and guard excursions below 20 percent detect output short.
// - fault indicator is latched, cleared only by power cycle or re-enable.
// - channel reaching target is good; later drop below target marks it open.
// - at over-voltage or lower temperature, channels not good become open at once.
module lfs_supervisor #(
	parameter int PWR_SHORT_CYC = `LFS_PWR_SHORT_CYC,
	parameter int OPEN_FAST_CYC = `LFS_OPEN_FAST_CYC
) (
	input wire logic core_clk, // 50 MHz clock
	input wire logic resetn, // async reset, active low
	input wire logic enable, // enable input
	input wire logic pwm_period, // pulse at each dimming period start
	input wire logic [5:0] cur_ok, // channel current at target
	input wire logic [5:0] pin_over_short, // channel pin voltage above short threshold
	input wire logic temp_low, // lower temperature comparator
	input wire logic temp_high, // upper temperature comparator
	input wire logic temp_cool, // cool-down comparator
	input wire logic over_voltage_guard, // output over-voltage comparator
	input wire logic guard_low_dip, // guard sense fell below 20 percent after rising
	input wire logic switch_node_fail, // switch node current or timing check failed
	output logic boost_run, // boost switching allowed
	output logic [5:0] led_channel_n_on, // current sink enables
	output logic [1:0] current_scale, // 0 full, 1 75%, 2 50%, 3 25%
	output logic fault_n, // latched fault, active low
	output logic fault_oe_n, // open-drain enable, low while pulling
	output logic shut_down // permanent shutdown
);
	lfs_pkg::lfs_state_e state_reg;
	lfs_pkg::lfs_scale_t scale_reg;
	logic [5:0] dis;
	logic enable_d_reg;
	logic out_short_reg;
	logic [31:0] pwr_cnt_reg;
	logic [31:0] fast_cnt_reg;
	logic fast_tick_reg;
	logic fault_reg;
	logic thermal_hit;
	logic clear;

	function automatic logic in_run(input lfs_pkg::lfs_state_e st);
		return st == lfs_pkg::LFS_RUN;
	endfunction

	// sinks and boost may run only in the active state with no upper trip
	function automatic logic sinks_live(input lfs_pkg::lfs_state_e st, input logic hot);
		return in_run(st) && !hot;
	endfunction

	assign clear = !enable;
	assign thermal_hit = temp_high && in_run(state_reg);

	// one tracker per sink, fed by the shared flags
	genvar g;
	generate
		for (g = 0; g < `LFS_NUM_CH; g++) begin : g_ch
			lfs_ch_if cif ();
			assign cif.clear = clear;
			assign cif.run = in_run(state_reg);
			assign cif.force_open = over_voltage_guard || temp_low;
			assign cif.fast = temp_low;
			assign cif.pwm_tick = pwm_period;
			assign cif.fast_tick = fast_tick_reg;
			assign cif.cur_ok = cur_ok[g];
			assign cif.over_short = pin_over_short[g];
			assign dis[g] = cif.disabled;
			lfs_channel u_ch (
				.core_clk(core_clk),
				.resetn(resetn),
				.cif(cif)
			);
		end
	endgenerate

	// cool-down restart waits for the upper flag to drop
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= lfs_pkg::LFS_OFF;
		end else begin
			case (state_reg)
				lfs_pkg::LFS_OFF: begin
					if (enable)
						state_reg <= lfs_pkg::LFS_RUN;
				end
				lfs_pkg::LFS_RUN: begin
					if (!enable)
						state_reg <= lfs_pkg::LFS_OFF;
					else if (out_short_reg)
						state_reg <= lfs_pkg::LFS_DEAD;
					else if (temp_high)
						state_reg <= lfs_pkg::LFS_THERMAL;
				end
				lfs_pkg::LFS_THERMAL: begin
					if (!enable)
						state_reg <= lfs_pkg::LFS_OFF;
					else if (out_short_reg)
						state_reg <= lfs_pkg::LFS_DEAD;
					else if (temp_cool && !temp_high)
						state_reg <= lfs_pkg::LFS_RUN;
				end
				lfs_pkg::LFS_DEAD: state_reg <= lfs_pkg::LFS_DEAD;
				default: state_reg <= lfs_pkg::LFS_OFF;
			endcase
		end
	end

	// one step per trip, holding at the lowest scale
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			scale_reg <= `LFS_SCALE_FULL;
		end else if (clear) begin
			scale_reg <= `LFS_SCALE_FULL;
		end else if (thermal_hit && scale_reg != `LFS_SCALE_25) begin
			scale_reg <= scale_reg + 2'h1;
		end
	end

	// output short detect, acted on no earlier than 31 ms after power-up
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pwr_cnt_reg <= 32'h0;
			out_short_reg <= 1'b0;
		end else begin
			if (pwr_cnt_reg != PWR_SHORT_CYC[31:0])
				pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
			if ((switch_node_fail || guard_low_dip) && pwr_cnt_reg == PWR_SHORT_CYC[31:0])
				out_short_reg <= 1'b1;
		end
	end

	// 800 us time base for the hot open-channel time-out
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fast_cnt_reg <= 32'h0;
			fast_tick_reg <= 1'b0;
		end else if (!temp_low) begin
			fast_cnt_reg <= 32'h0;
			fast_tick_reg <= 1'b0;
		end else if (fast_cnt_reg == OPEN_FAST_CYC[31:0] - 32'h1) begin
			fast_cnt_reg <= 32'h0;
			fast_tick_reg <= 1'b1;
		end else begin
			fast_cnt_reg <= fast_cnt_reg + 32'h1;
			fast_tick_reg <= 1'b0;
		end
	end

	// rising enable marks a re-enable
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			enable_d_reg <= 1'b0;
		end else begin
			enable_d_reg <= enable;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fault_reg <= 1'b0;
		end else if (enable && !enable_d_reg) begin
			fault_reg <= 1'b0;
		end else if (|dis || temp_high || over_voltage_guard || (|pin_over_short) || out_short_reg) begin
			fault_reg <= 1'b1;
		end
	end

	// boost stops the cycle after an upper trip is seen
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			boost_run <= 1'b0;
		end else begin
			boost_run <= sinks_live(state_reg, temp_high);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			led_channel_n_on <= 6'h00;
		end else begin
			led_channel_n_on <= sinks_live(state_reg, temp_high) ? ~dis : 6'h00;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			current_scale <= `LFS_SCALE_FULL;
		end else begin
			current_scale <= scale_reg;
		end
	end

	// open-drain pin pulls low while the latched fault stands
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fault_n <= 1'b1;
			fault_oe_n <= 1'b1;
		end else begin
			fault_n <= !fault_reg;
			fault_oe_n <= !fault_reg;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			shut_down <= 1'b0;
		end else begin
			shut_down <= state_reg == lfs_pkg::LFS_DEAD;
		end
	end
endmodule

//--- tb/lfs_sinks.sv
`timescale 1ns/1ps
module lfs_sinks (
	input wire logic [5:0] on, // sink enables
	input wire logic [5:0] broken, // strings that lost current
	input wire logic [5:0] shorted, // strings with pin over short level
	output logic [5:0] cur_ok, // current at target
	output logic [5:0] pin_over_short // pin comparator
);
	// a sink that is off carries no current and shows no pin excess
	assign cur_ok = on & ~broken;
	assign pin_over_short = on & shorted;
endmodule

//--- tb/lfs_supervisor_properties.sv
`timescale 1ns/1ps
module lfs_supervisor_properties #(
	parameter int PWR_SHORT_CYC = 100,
	parameter int OPEN_FAST_CYC = 50
) (
	input wire logic core_clk, // clock
	input wire logic resetn, // reset
	input wire logic enable, // enable
	input wire logic temp_high, // upper trip
	input wire logic over_voltage_guard, // over-voltage
	input wire logic boost_run, // boost
	input wire logic [5:0] led_channel_n_on, // sinks
	input wire logic [1:0] current_scale, // scale
	input wire logic fault_n, // fault
	input wire logic fault_oe_n, // pin enable
	input wire logic shut_down // dead
);
	int up_cyc;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			up_cyc <= 0;
		else if (up_cyc < PWR_SHORT_CYC)
			up_cyc <= up_cyc + 1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	hot_stop_a: assert property (temp_high |=> !boost_run && led_channel_n_on == 6'h00)
		else $error("sinks on after upper trip");
	oe_match_a: assert property (fault_oe_n == fault_n)
		else $error("fault pin enable differs");
	scale_step_a: assert property (!$stable(current_scale) |->
		current_scale == $past(current_scale) + 2'h1 || current_scale == 2'h0) else $error("bad scale step");
	fault_hold_a: assert property (!fault_n && enable && $past(enable) && $past(enable, 2) &&
		$past(enable, 3) |=> !fault_n) else $error("fault cleared while enabled");
	trip_flag_a: assert property (enable && $past(enable) && $past(enable, 2) &&
		(temp_high || over_voltage_guard) |-> ##2 !fault_n) else $error("trip not flagged");
	off_idle_a: assert property (!enable |-> ##2 (!boost_run && led_channel_n_on == 6'h00))
		else $error("running while disabled");
	dead_hold_a: assert property (shut_down |=> shut_down && !boost_run)
		else $error("shutdown not held");
	early_short_a: assert property (up_cyc < PWR_SHORT_CYC - 1 |-> !shut_down)
		else $error("shutdown too early");
	drop_flag_a: assert property (enable && $past(enable, 2) && boost_run && $past(boost_run) &&
		($past(led_channel_n_on) & ~led_channel_n_on) != 6'h00 |=> !fault_n) else $error("drop unflagged");
endmodule
bind lfs_supervisor lfs_supervisor_properties #(.PWR_SHORT_CYC(PWR_SHORT_CYC), .OPEN_FAST_CYC(OPEN_FAST_CYC)) chk_i (
	.core_clk(core_clk), .resetn(resetn), .enable(enable), .temp_high(temp_high),
	.over_voltage_guard(over_voltage_guard), .boost_run(boost_run), .led_channel_n_on(led_channel_n_on),
	.current_scale(current_scale), .fault_n(fault_n), .fault_oe_n(fault_oe_n), .shut_down(shut_down));

//--- tb/lfs_supervisor_tb.sv
`timescale 1ns/1ps
module lfs_supervisor_tb;
	logic core_clk = 0, resetn = 0, enable = 0, pwm_period = 0, temp_low = 0, temp_high = 0, temp_cool = 0;
	logic over_voltage_guard = 0, switch_node_fail = 0, guard_low_dip = 0, boost_run, fault_n, fault_oe_n, shut_down;
	logic [5:0] broken = 6'h00, shorted = 6'h00, cur_ok, pin_over_short, on;
	logic [1:0] current_scale;
	int fails = 0, tests_run = 0;
	initial forever #10 core_clk = ~core_clk;
	lfs_supervisor #(.PWR_SHORT_CYC(100), .OPEN_FAST_CYC(50)) DUT (.core_clk(core_clk), .resetn(resetn),
		.enable(enable), .pwm_period(pwm_period), .cur_ok(cur_ok), .pin_over_short(pin_over_short),
		.temp_low(temp_low), .temp_high(temp_high), .temp_cool(temp_cool), .over_voltage_guard(over_voltage_guard),
		.guard_low_dip(guard_low_dip), .switch_node_fail(switch_node_fail), .boost_run(boost_run),
		.led_channel_n_on(on), .current_scale(current_scale), .fault_n(fault_n), .fault_oe_n(fault_oe_n),
		.shut_down(shut_down));
	lfs_sinks partner (.on(on), .broken(broken), .shorted(shorted), .cur_ok(cur_ok), .pin_over_short(pin_over_short));
	task chk(input string what, input logic [5:0] exp, input logic [5:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task pulses(input int n);
		repeat (n) begin
			pwm_period <= 1;
			cyc(1);
			pwm_period <= 0;
			cyc(3);
		end
	endtask
	task restart(input logic [5:0] b);
		enable <= 0;
		shorted <= 6'h00;
		broken <= b;
		cyc(3);
		enable <= 1;
		cyc(6);
	endtask
	task t_open;
		restart(6'h00);
		chk("fault", 6'h01, fault_n);
		broken <= 6'h01;
		cyc(3);
		pulses(5);
		chk("sinks", 6'h3F, on);
		pulses(1);
		chk("sinks", 6'h3E, on);
		cyc(1);
		chk("fault", 6'h00, fault_n);
		chk("fault pin", 6'h00, fault_oe_n);
	endtask
	task t_short;
		restart(6'h00);
		shorted <= 6'h04;
		cyc(3);
		pulses(5);
		chk("sinks", 6'h3F, on);
		pulses(1);
		chk("sinks", 6'h3B, on);
	endtask
	task t_ov;
		restart(6'h20);
		pulses(7);
		chk("sinks", 6'h3F, on);
		over_voltage_guard <= 1;
		cyc(3);
		pulses(6);
		over_voltage_guard <= 0;
		chk("sinks", 6'h1F, on);
	endtask
	task t_thermal;
		restart(6'h00);
		for (int k = 1; k < 5; k++) begin
			temp_high <= 1;
			cyc(2);
			chk("sinks", 6'h00, on);
			chk("boost", 6'h00, boost_run);
			temp_high <= 0;
			temp_cool <= 1;
			cyc(4);
			temp_cool <= 0;
			chk("scale", (k > 3) ? 6'h03 : 6'(k), current_scale);
			chk("boost", 6'h01, boost_run);
			chk("sinks", 6'h3F, on);
		end
	endtask
	task t_fast;
		restart(6'h00);
		temp_low <= 1;
		broken <= 6'h02;
		cyc(110);
		temp_low <= 0;
		chk("sinks", 6'h3D, on);
	endtask
	task t_dead;
		resetn <= 0;
		cyc(2);
		resetn <= 1;
		restart(6'h00);
		switch_node_fail <= 1;
		cyc(20);
		chk("dead", 6'h00, shut_down);
		cyc(100);
		chk("dead", 6'h01, shut_down);
		chk("boost", 6'h00, boost_run);
	endtask
	task t_dip;
		resetn <= 0;
		switch_node_fail <= 0;
		cyc(2);
		resetn <= 1;
		restart(6'h00);
		guard_low_dip <= 1;
		cyc(20);
		guard_low_dip <= 0;
		cyc(100);
		chk("dead", 6'h00, shut_down);
		guard_low_dip <= 1;
		cyc(4);
		chk("dead", 6'h01, shut_down);
		chk("sinks", 6'h00, on);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		give_verdict;
	end
	initial begin
		cyc(20);
		resetn <= 1;
		cyc(2);
		t_open;
		t_short;
		t_ov;
		t_thermal;
		t_fast;
		t_dead;
		t_dip;
		give_verdict;
	end
endmodule
